// File: hdl/gauge_command_regs.v
// Purpose: indicator, link and command register bank of the pack gauge
// Assumes: a link engine delivers decoded byte writes/reads with CRC status
// Notes:   command effects leave as one-cycle pulses to the gauge core, except the o_settings_editable and o_setup_mode levels
`timescale 1ns/1ps
`include "gauge_regs_consts.vh"

module gauge_command_regs #(
    parameter [39:0] VARIANT_TEXT        = 40'h5641523031, // arbitrary neutral text
    parameter        DEGLITCH_STEP_CYCLES = `DEGLITCH_STEP_CYCLES,
    parameter        ON_TIME_STEP_CYCLES  = `ON_TIME_STEP_CYCLES
) (
    input  wire        i_mclk,
    input  wire        i_sys_rst,
    input  wire        i_wr,
    input  wire        i_rd,
    input  wire [15:0] i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_crc_present,
    input  wire        i_crc_ok,
    input  wire        i_charging,
    input  wire        i_button,
    input  wire [4:0]  i_soc_level,
    output reg  [7:0]  o_rdata,
    output reg         o_rvalid,
    output reg         o_wr_refused,
    output reg  [6:0]  o_slave_addr,
    output reg         o_append_crc,
    output reg  [4:0]  o_indicator,
    output reg         o_gauge_reset,
    output reg         o_estimate_start,
    output reg         o_settings_editable,
    output reg         o_setup_mode,
    output reg         o_store_config,
    output reg         o_store_settings,
    output reg         o_defaults_restore,
    output reg         o_log_clear
);
    reg  [7:0] indicator_control;
    reg  [6:0] transition_deglitch_time;
    reg  [3:0] button_display_duration;
    reg  [7:0] link_config;
    reg        charging_s1;
    reg        charging_s2;
    reg        button_s1;
    reg        button_s2;
    reg        button_d;
    reg        charging_shown;
    reg        charging_d;
    reg        next_exit_pending;
    wire       crc_on;
    wire       wr_ok;
    wire       cmd_hit;
    wire       button_press;
    wire       deglitch_busy;
    wire       button_busy;
    wire       manual_indicator_select;
    wire       show_charge_while_charging;
    wire       show_charge_on_button;
    wire [4:0] indicator_force_on;
    reg  [4:0] next_indicator;
    reg  [7:0] next_rdata;
    reg  [2:0] variant_idx;

    assign crc_on                     = link_config[`BIT_CRC_ENABLE];
    assign manual_indicator_select    = indicator_control[`BIT_MANUAL_SELECT];
    assign show_charge_while_charging = indicator_control[`BIT_SHOW_CHARGING];
    assign show_charge_on_button      = indicator_control[`BIT_SHOW_BUTTON];
    assign indicator_force_on         = indicator_control[`BIT_FORCE_LSB+4:`BIT_FORCE_LSB];
    // crc enabled: correct crc required; disabled: absent or correct crc accepted
    assign wr_ok   = i_wr & (crc_on ? (i_crc_present & i_crc_ok)
                                    : (~i_crc_present | i_crc_ok));
    assign cmd_hit = wr_ok & (i_wdata == `CMD_EXECUTE);
    assign button_press = button_s2 & ~button_d;

    // pin inputs pass two flip-flops
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            charging_s1 <= 1'b0;
            charging_s2 <= 1'b0;
            button_s1   <= 1'b0;
            button_s2   <= 1'b0;
            button_d    <= 1'b0;
            charging_d  <= 1'b0;
        end else begin
            charging_s1 <= i_charging;
            charging_s2 <= charging_s1;
            button_s1   <= i_button;
            button_s2   <= button_s1;
            button_d    <= button_s2;
            charging_d  <= charging_s2;
        end
    end

    step_timer #(
        .STEP_CYCLES (DEGLITCH_STEP_CYCLES),
        .STEP_W      (7)
    ) u_deglitch (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_start   (charging_s2 != charging_d),
        .i_steps   (transition_deglitch_time),
        .o_busy    (deglitch_busy)
    );

    step_timer #(
        .STEP_CYCLES (ON_TIME_STEP_CYCLES),
        .STEP_W      (5)
    ) u_button (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_start   (button_press & show_charge_on_button),
        .i_steps   ({1'b0, button_display_duration} + 5'h01),
        .o_busy    (button_busy)
    );

    // charging state seen by the indicators only after the deglitch expires
    always @(posedge i_mclk) begin
        if (i_sys_rst)
            charging_shown <= 1'b0;
        else if (!deglitch_busy && (charging_s2 == charging_d))
            charging_shown <= charging_s2;
    end

    always @* begin
        if (manual_indicator_select)
            next_indicator = indicator_force_on;
        else if ((charging_shown && show_charge_while_charging) || button_busy)
            next_indicator = i_soc_level;
        else
            next_indicator = 5'h00;
    end

    // register writes and command pulses
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            indicator_control        <= `RST_INDICATOR_CONTROL;
            transition_deglitch_time <= `RST_DEGLITCH;
            button_display_duration  <= `RST_ON_TIME;
            link_config              <= `RST_LINK_CONFIG;
            o_gauge_reset            <= 1'b0;
            o_estimate_start         <= 1'b0;
            o_settings_editable      <= 1'b0;
            o_setup_mode             <= 1'b0;
            o_store_config           <= 1'b0;
            o_store_settings         <= 1'b0;
            o_defaults_restore       <= 1'b0;
            o_log_clear              <= 1'b0;
            next_exit_pending        <= 1'b0;
            o_wr_refused             <= 1'b0;
            o_indicator              <= 5'h00;
            o_slave_addr             <= 7'h00;
            o_append_crc             <= 1'b0;
        end else begin
            o_gauge_reset      <= next_exit_pending;
            o_estimate_start   <= 1'b0;
            o_store_config     <= 1'b0;
            o_store_settings   <= 1'b0;
            o_defaults_restore <= 1'b0;
            o_log_clear        <= 1'b0;
            next_exit_pending  <= 1'b0;
            o_wr_refused       <= i_wr & ~wr_ok;
            o_indicator        <= next_indicator;
            o_slave_addr       <= link_config[6:0];
            o_append_crc       <= crc_on;
            if (wr_ok) begin
                case (i_addr)
                    `ADDR_INDICATOR_CONTROL:  indicator_control <= i_wdata;
                    `ADDR_INDICATOR_DEGLITCH: transition_deglitch_time <= i_wdata[6:0];
                    `ADDR_INDICATOR_ON_TIME:  button_display_duration <= i_wdata[3:0];
                    `ADDR_LINK_CONFIG:        link_config <= i_wdata;
                    default: ;
                endcase
            end
            if (cmd_hit) begin
                case (i_addr)
                    `ADDR_GAUGE_RESET:
                        o_gauge_reset <= 1'b1;
                    `ADDR_ESTIMATE_TRIGGER:
                        o_estimate_start <= 1'b1;
                    `ADDR_SETTINGS_UNLOCK:
                        o_settings_editable <= 1'b1;
                    `ADDR_SETTINGS_LOCK:
                        o_settings_editable <= 1'b0;
                    `ADDR_SETUP_ENTER:
                        o_setup_mode <= 1'b1;
                    `ADDR_SETUP_EXIT: begin
                        if (o_setup_mode) begin
                            o_store_config    <= 1'b1;
                            o_setup_mode      <= 1'b0;
                            next_exit_pending <= 1'b1;
                        end else begin
                            o_store_settings <= 1'b1;
                        end
                    end
                    `ADDR_DEFAULTS_RESTORE: begin
                        o_defaults_restore       <= 1'b1;
                        o_gauge_reset            <= 1'b1;
                        indicator_control        <= `RST_INDICATOR_CONTROL;
                        transition_deglitch_time <= `RST_DEGLITCH;
                        button_display_duration  <= `RST_ON_TIME;
                        link_config              <= `RST_LINK_CONFIG;
                    end
                    `ADDR_LOG_CLEAR:
                        o_log_clear <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // read path; command registers read zero
    always @* begin
        variant_idx = i_addr[2:0];
        case (i_addr)
            `ADDR_INDICATOR_CONTROL:  next_rdata = indicator_control;
            `ADDR_INDICATOR_DEGLITCH: next_rdata = {1'b0, transition_deglitch_time};
            `ADDR_INDICATOR_ON_TIME:  next_rdata = {4'h0, button_display_duration};
            `ADDR_LINK_CONFIG:        next_rdata = link_config;
            default: begin
                if (i_addr >= `ADDR_VARIANT_BASE && i_addr <= `ADDR_VARIANT_LAST)
                    next_rdata = VARIANT_TEXT[8*variant_idx +: 8];
                else
                    next_rdata = 8'h00;
            end
        endcase
    end

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_rdata  <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd;
            o_rdata  <= i_rd ? next_rdata : 8'h00;
        end
    end
endmodule

// File: hdl/gauge_regs_consts.vh
// Purpose: constants of the gauge command and indicator register bank
// Assumes: 16-bit register addresses, 8-bit data
// Notes:   timing counts derived from a 50 MHz clock
`ifndef GAUGE_REGS_CONSTS_VH
`define GAUGE_REGS_CONSTS_VH
`define ADDR_INDICATOR_CONTROL   16'h4000
`define ADDR_INDICATOR_DEGLITCH  16'h4001
`define ADDR_INDICATOR_ON_TIME   16'h4002
`define ADDR_LINK_CONFIG         16'h4100
`define ADDR_VARIANT_BASE        16'h6100
`define ADDR_VARIANT_LAST        16'h6104
`define ADDR_LOG_CLEAR           16'h7ff8
`define ADDR_DEFAULTS_RESTORE    16'h7ff9
`define ADDR_SETUP_EXIT          16'h7ffa
`define ADDR_SETUP_ENTER         16'h7ffb
`define ADDR_SETTINGS_LOCK       16'h7ffc
`define ADDR_SETTINGS_UNLOCK     16'h7ffd
`define ADDR_ESTIMATE_TRIGGER    16'h7ffe
`define ADDR_GAUGE_RESET         16'h7fff
`define CMD_EXECUTE              8'h01
`define BIT_MANUAL_SELECT        0
`define BIT_SHOW_CHARGING        1
`define BIT_SHOW_BUTTON          2
`define BIT_FORCE_LSB            3
`define BIT_CRC_ENABLE           7
`define RST_INDICATOR_CONTROL    8'h06
`define RST_DEGLITCH             7'h28
`define RST_ON_TIME              4'h4
`define RST_LINK_CONFIG          8'h88
`define CLK_HZ                   50000000
`define DEGLITCH_STEP_MS         100
`define ON_TIME_STEP_MS          1000
`define DEGLITCH_STEP_CYCLES     ((`CLK_HZ / 1000) * `DEGLITCH_STEP_MS)
`define ON_TIME_STEP_CYCLES      ((`CLK_HZ / 1000) * `ON_TIME_STEP_MS)
`endif

// File: hdl/step_timer.v
// Purpose: counts a programmed number of fixed-length time steps
// Assumes: i_start is a one-cycle pulse; restarting reloads the count
// Notes:   o_busy is high for (i_steps * STEP_CYCLES) cycles after start
`timescale 1ns/1ps
module step_timer #(
    parameter STEP_CYCLES = 5000000,
    parameter STEP_W      = 7
) (
    input  wire              i_mclk,
    input  wire              i_sys_rst,
    input  wire              i_start,
    input  wire [STEP_W-1:0] i_steps,
    output reg               o_busy
);
    reg [31:0]       tick;
    reg [STEP_W-1:0] left;

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tick   <= 32'h0;
            left   <= {STEP_W{1'b0}};
            o_busy <= 1'b0;
        end else if (i_start) begin
            tick   <= 32'h0;
            left   <= i_steps;
            o_busy <= (i_steps != {STEP_W{1'b0}});
        end else if (o_busy) begin
            if (tick == STEP_CYCLES - 1) begin
                tick <= 32'h0;
                left <= left - {{(STEP_W-1){1'b0}}, 1'b1};
                if (left == {{(STEP_W-1){1'b0}}, 1'b1})
                    o_busy <= 1'b0;
            end else begin
                tick <= tick + 32'h1;
            end
        end
    end
endmodule

// File: verif/gauge_led_link_command_regs_tb.sv
// Purpose: self-checking bench of the gauge command register bank
// Assumes: short step counts of 10 and 20 cycles
// Notes:   outputs checked on the falling edge after each transfer
`timescale 1ns/1ps
module gauge_led_link_command_regs_tb;
    localparam [39:0] VT = 40'h4142433031; // arbitrary neutral text
    reg         i_mclk, i_sys_rst, i_charging, i_button;
    reg  [4:0]  i_soc_level;
    wire        i_wr, i_rd, i_crc_present, i_crc_ok;
    wire [15:0] i_addr;
    wire [7:0]  i_wdata, o_rdata;
    wire [6:0]  o_slave_addr;
    wire [4:0]  o_indicator;
    wire        o_rvalid, o_wr_refused, o_append_crc, o_gauge_reset, o_estimate_start;
    wire        o_settings_editable, o_setup_mode, o_store_config, o_store_settings;
    wire        o_defaults_restore, o_log_clear;
    wire [5:0]  pv = {o_gauge_reset, o_estimate_start, o_store_config, o_store_settings,
                      o_defaults_restore, o_log_clear};
    integer     err_count, checks_done, k;
    host_link_model host (.i_mclk(i_mclk), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
        .o_wdata(i_wdata), .o_crc_present(i_crc_present), .o_crc_ok(i_crc_ok));
    gauge_command_regs #(.VARIANT_TEXT(VT), .DEGLITCH_STEP_CYCLES(10),
        .ON_TIME_STEP_CYCLES(20)) DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_crc_present(i_crc_present), .i_crc_ok(i_crc_ok), .i_charging(i_charging),
        .i_button(i_button), .i_soc_level(i_soc_level), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_wr_refused(o_wr_refused), .o_slave_addr(o_slave_addr),
        .o_append_crc(o_append_crc), .o_indicator(o_indicator),
        .o_gauge_reset(o_gauge_reset), .o_estimate_start(o_estimate_start),
        .o_settings_editable(o_settings_editable), .o_setup_mode(o_setup_mode),
        .o_store_config(o_store_config), .o_store_settings(o_store_settings),
        .o_defaults_restore(o_defaults_restore), .o_log_clear(o_log_clear));
    task chk(input string n, input logic [39:0] s, input logic [39:0] e);
        begin
            checks_done = checks_done + 1;
            if (s !== e) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            end
        end
    endtask
    task w(input [15:0] a, input [7:0] d);
        host.put(a, d, 1'b1, 1'b1);
    endtask
    task r(input [15:0] a, input [7:0] e);
        begin
            host.get(a);
            chk("read", {o_rvalid, o_rdata}, {1'b1, e});
        end
    endtask
    task idle(input integer n);
        repeat (n) @(negedge i_mclk);
    endtask
    task press;
        begin
            i_button = 1'b1;
            idle(3);
            i_button = 1'b0;
            idle(5);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    initial begin
        #1000000;
        err_count = err_count + 1;
        test_done;
    end
    initial begin
        err_count = 0;
        checks_done = 0;
        {i_sys_rst, i_charging, i_button, i_soc_level} = {3'b100, 5'h0b};
        idle(8);
        i_sys_rst = 1'b0;
        idle(2);
        chk("link", {o_append_crc, o_slave_addr}, 8'h88);
        r(16'h4000, 8'h06);
        r(16'h4001, 8'h28);
        r(16'h4002, 8'h04);
        for (k = 0; k < 5; k = k + 1)
            r(16'h6100 + k[15:0], VT[8*k +: 8]);
        w(16'h6100, 8'h00);
        r(16'h6100, VT[7:0]);
        r(16'h5000, 8'h00);
        $display("test reset values done");
        host.put(16'h4001, 8'h33, 1'b0, 1'b0);
        chk("refuse", o_wr_refused, 1'b1);
        host.put(16'h4001, 8'h33, 1'b1, 1'b0);
        chk("refuse", o_wr_refused, 1'b1);
        r(16'h4001, 8'h28);
        w(16'h4100, 8'h15);
        idle(1);
        chk("link", {o_append_crc, o_slave_addr}, 8'h15);
        host.put(16'h4001, 8'h33, 1'b0, 1'b0);
        chk("refuse", o_wr_refused, 1'b0);
        host.put(16'h4001, 8'h44, 1'b1, 1'b0);
        chk("refuse", o_wr_refused, 1'b1);
        r(16'h4001, 8'h33);
        w(16'h4100, 8'h88);
        idle(1);
        chk("crc", o_append_crc, 1'b1);
        $display("test link policy done");
        for (k = 0; k < 8; k = k + 1) begin
            w(16'h7ff8 + k[15:0], 8'h02);
            chk("ignored", {o_settings_editable, o_setup_mode, pv}, 8'h00);
            r(16'h7ff8 + k[15:0], 8'h00);
        end
        w(16'h7ffe, 8'h01); // fresh readings assumed loaded
        chk("trigger", pv, 6'h10);
        w(16'h7fff, 8'h01);
        chk("reset", pv, 6'h20);
        w(16'h7ff8, 8'h01);
        chk("log", pv, 6'h01);
        w(16'h7ffd, 8'h01);
        chk("unlock", o_settings_editable, 1'b1);
        w(16'h7ffc, 8'h01);
        chk("lock", o_settings_editable, 1'b0);
        w(16'h7ffa, 8'h01);
        chk("store", pv, 6'h04);
        w(16'h7ffb, 8'h01);
        chk("setup", o_setup_mode, 1'b1);
        w(16'h7ffa, 8'h01);
        chk("save", pv, 6'h08);
        idle(1);
        chk("save", pv, 6'h20);
        w(16'h4001, 8'h11);
        w(16'h7ff9, 8'h01);
        chk("restore", o_defaults_restore, 1'b1);
        idle(2);
        r(16'h4001, 8'h28);
        $display("test commands done");
        w(16'h4001, 8'h02);
        w(16'h4002, 8'h01);
        w(16'h4000, 8'ha9);
        idle(1);
        chk("leds", o_indicator, 5'h15);
        w(16'h4000, 8'h02);
        i_charging = 1'b1;
        idle(5);
        chk("leds", o_indicator, 5'h00);
        idle(30);
        chk("leds", o_indicator, 5'h0b);
        w(16'h4000, 8'h00);
        idle(1);
        chk("leds", o_indicator, 5'h00);
        i_charging = 1'b0;
        idle(30);
        press;
        chk("leds", o_indicator, 5'h00);
        w(16'h4000, 8'h04);
        press;
        chk("leds", o_indicator, 5'h0b);
        idle(27);
        chk("leds", o_indicator, 5'h0b);
        idle(25);
        chk("leds", o_indicator, 5'h00);
        $display("test indicators done");
        test_done;
    end
endmodule
bind gauge_command_regs gauge_regs_asserts u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_crc_present(i_crc_present), .i_crc_ok(i_crc_ok), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_wr_refused(o_wr_refused), .o_append_crc(o_append_crc),
    .o_indicator(o_indicator), .o_gauge_reset(o_gauge_reset),
    .o_estimate_start(o_estimate_start), .o_settings_editable(o_settings_editable),
    .o_setup_mode(o_setup_mode), .o_store_config(o_store_config),
    .o_log_clear(o_log_clear));

// File: verif/gauge_regs_asserts.sv
// Purpose: port assertions of the gauge command register bank
// Assumes: one clock, synchronous active-high reset
// Notes:   an accepted write carries correct CRC, or none while CRC is off
`timescale 1ns/1ps
module gauge_regs_asserts (
    input wire        i_mclk,
    input wire        i_sys_rst,
    input wire        i_wr,
    input wire        i_rd,
    input wire [15:0] i_addr,
    input wire [7:0]  i_wdata,
    input wire        i_crc_present,
    input wire        i_crc_ok,
    input wire [7:0]  o_rdata,
    input wire        o_rvalid,
    input wire        o_wr_refused,
    input wire        o_append_crc,
    input wire [4:0]  o_indicator,
    input wire        o_gauge_reset,
    input wire        o_estimate_start,
    input wire        o_settings_editable,
    input wire        o_setup_mode,
    input wire        o_store_config,
    input wire        o_log_clear
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // crc off: a write without crc bytes is accepted as well
    wire ok_wr = i_wr && (i_crc_present ? i_crc_ok : !o_append_crc);
    wire go    = ok_wr && (i_wdata == 8'h01);
    a_trigger_pulse: assert property (go && i_addr == 16'h7ffe |=> o_estimate_start)
        else $error("estimate start missing");
    a_trigger_cause: assert property (o_estimate_start |-> $past(go && i_addr == 16'h7ffe))
        else $error("estimate start without command");
    a_gauge_reset: assert property (go && i_addr == 16'h7fff |=> o_gauge_reset)
        else $error("gauge reset missing");
    a_log_clear: assert property (go && i_addr == 16'h7ff8 |=> o_log_clear)
        else $error("log clear missing");
    a_unlock_level: assert property (go && i_addr == 16'h7ffd |=> o_settings_editable)
        else $error("settings not editable");
    a_lock_level: assert property (go && i_addr == 16'h7ffc |=> !o_settings_editable)
        else $error("settings still editable");
    a_exit_order: assert property (o_setup_mode && go && i_addr == 16'h7ffa
        |=> o_store_config ##1 o_gauge_reset)
        else $error("setup exit order wrong");
    a_crc_refuse: assert property (i_wr && o_append_crc && !(i_crc_present && i_crc_ok)
        |=> o_wr_refused)
        else $error("bad write not refused");
    a_cmd_readzero: assert property (i_rd && i_addr >= 16'h7ff8
        |=> o_rvalid && o_rdata == 8'h00)
        else $error("command register read not zero");
    a_manual_drive: assert property (ok_wr && i_addr == 16'h4000 && i_wdata[0]
        |=> ##1 o_indicator == $past(i_wdata[7:3], 2))
        else $error("manual indicators wrong");
    cover property (o_setup_mode && go && i_addr == 16'h7ffa);
    cover property (o_wr_refused);
    cover property (o_rvalid && o_rdata != 8'h00);
endmodule

// File: verif/host_link_model.sv
// Purpose: system controller model issuing byte link transfers
// Assumes: requests launched on the falling clock edge
// Notes:   idle address and data show the inverse of the last value
`timescale 1ns/1ps
module host_link_model (
    input  wire        i_mclk,
    output reg         o_wr,
    output reg         o_rd,
    output reg  [15:0] o_addr,
    output reg  [7:0]  o_wdata,
    output reg         o_crc_present,
    output reg         o_crc_ok
);
    initial {o_wr, o_rd, o_addr, o_wdata, o_crc_present, o_crc_ok} = 28'h0;
    task drop;
        {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~o_addr, ~o_wdata};
    endtask
    // write held over one rising edge with its CRC status
    task put(input [15:0] a, input [7:0] d, input p, input k);
        begin
            @(negedge i_mclk);
            {o_wr, o_addr, o_wdata, o_crc_present, o_crc_ok} = {1'b1, a, d, p, k};
            @(negedge i_mclk);
            drop;
        end
    endtask
    task get(input [15:0] a);
        begin
            @(negedge i_mclk);
            {o_rd, o_addr} = {1'b1, a};
            @(negedge i_mclk);
            drop;
        end
    endtask
endmodule
